// *** rtl/ul_csum.sv ***
// checksum over one log word payload and its address
`timescale 1ns/1ps
module ul_csum (
  input  wire logic [23:0] payload,
  input  wire logic [9:0]  addr,
  output logic      [7:0]  csum
);
  // address is folded in so a word landing in the wrong slot fails too
  assign csum = ~(payload[23:16] + payload[15:8] + payload[7:0]
                  + addr[7:0] + {6'h00, addr[9:8]});
endmodule // ul_csum

// *** rtl/ul_interval_timer.sv ***
// seconds prescaler and programmable sampling tick
`timescale 1ns/1ps
module ul_interval_timer #(
  parameter int unsigned SEC_CYC = ul_pkg::SEC_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        run,
  input  wire logic [11:0] interval,
  output logic             tick
);
  localparam int unsigned PW = $clog2(SEC_CYC);
  localparam logic [PW-1:0] PRE_LAST = PW'(SEC_CYC - 1);

  logic [PW-1:0] pre_q;    // cycles within the current second
  logic [11:0]   sec_q;    // seconds within the current interval
  logic [11:0]   ivl_eff;  // interval forced into its legal span
  logic          sec_hit;  // last cycle of a second
  logic          tick_q;

  // out-of-range settings are clamped rather than refused
  always_comb
  begin
    ivl_eff = interval;
    if (interval < 12'(ul_pkg::IVL_MIN_S))
      ivl_eff = 12'(ul_pkg::IVL_MIN_S);
    else if (interval > 12'(ul_pkg::IVL_MAX_S))
      ivl_eff = 12'(ul_pkg::IVL_MAX_S);
  end

  assign sec_hit = run & (pre_q == PRE_LAST);

  // one-second prescaler, held at zero while logging is off
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_q <= '0;
    else if (!run || sec_hit)
      pre_q <= '0;
    else
      pre_q <= pre_q + PW'(1);
  end

  // a shrunk interval ends the current one at the next second boundary (>= compare)
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sec_q  <= 12'h000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (!run)
        sec_q <= 12'h000;
      else if (sec_hit)
      begin
        if (sec_q + 12'h001 >= ivl_eff)
        begin
          sec_q  <= 12'h000;
          tick_q <= 1'b1;
        end
        else
          sec_q <= sec_q + 12'h001;
      end
    end
  end

  assign tick = tick_q;

  a_tick_on_time: assert property (@(posedge clk) disable iff (!arst_n)
    sec_hit && (sec_q + 12'h001 == ivl_eff) |=> tick)
    else $error("interval tick missing");
  a_tick_cause: assert property (@(posedge clk) disable iff (!arst_n)
    tick |-> $past(sec_hit) && $past(ivl_eff) >= 12'h004)
    else $error("tick without elapsed second");
endmodule // ul_interval_timer

// *** rtl/ul_logger.sv ***
// usage data logger: sampling, change logging and log memory writes
//
// Summary of operation
// - sample state every 4 s to 60 min
// - keep the log in non-volatile memory
// - enabling takes effect at next power-up
// - short and long-term logs share one interval
// - circular entries hold five state values
// - each interval bumps current memory's counter (the code writes a shadow count that restarts from zero each power-up)
// - room for 750 entries and 4 counters
// - every stored word carries a checksum
// - extra entry on memory, volume, battery change
// - optional entry on large ambient change
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module ul_logger #(
  parameter int unsigned SEC_CYC = ul_pkg::SEC_CYC,
  parameter int unsigned ENTRIES = ul_pkg::ENTRIES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire ul_pkg::ul_entry_t state_i,
  input  wire logic              nvm_arm_i,
  output logic                   nvm_req_o,
  output ul_pkg::ul_nvm_t        nvm_o,
  input  wire logic              nvm_ack_i
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  localparam logic [9:0] PTR_LAST = 10'(ENTRIES - 1);

  // arm flag read back from the log memory at power-up
  logic       arm_s1_q;   // first sync stage
  logic       arm_s2_q;   // second sync stage
  logic [1:0] cap_cnt_q;  // cycles since reset release
  logic       active_q;   // logging runs this power cycle

  // bus side
  logic        wb_req;
  logic        wb_wr;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;
  logic        ctrl_en_q;  // enable requested for next power-up
  logic        lvl_en_q;   // ambient change logging on
  logic [11:0] ivl_q;      // sampling interval in seconds
  logic [7:0]  thr_q;      // ambient change threshold

  // event side
  logic              tick;
  ul_pkg::ul_entry_t snap_q;  // state as last logged
  logic [7:0]        amb_diff;
  logic              chg_state;
  logic              amb_chg;
  logic              ent_pend_q;
  logic              cnt_pend_q;
  logic              arm_pend_q;
  logic              arm_set;

  // log writer
  ul_pkg::ul_state_t st_q;
  ul_pkg::ul_nvm_t   nvm_q;
  logic              req_q;
  logic [9:0]        wptr_q;     // next entry slot
  logic              wrapped_q;  // buffer has been filled once
  logic [ul_pkg::CNT_W-1:0] cnt_q [ul_pkg::MEM_STATES];
  logic [1:0]        cnt_mem_q;  // counter being written
  logic              go_ent;
  logic              go_cnt;
  logic              go_arm;
  logic [23:0]       pay;
  logic [9:0]        pay_addr;
  logic [7:0]        csum;

  // two-stage synchroniser for the arm flag pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arm_s1_q <= 1'b0;
      arm_s2_q <= 1'b0;
    end
    else
    begin
      arm_s1_q <= nvm_arm_i;
      arm_s2_q <= arm_s1_q;
    end
  end

  // catch the arm flag once; a later enable write waits for power-up
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_cnt_q <= 2'h0;
      active_q  <= 1'b0;
    end
    else if (cap_cnt_q != ul_pkg::CAP_DONE)
    begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == ul_pkg::CAP_LAST)
        active_q <= arm_s2_q;
    end
  end

  // classic bus slave: one wait state, writes land on the ack edge
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_we_i & ack_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_q <= 1'b0;
    else
      ack_q <= wb_req & ~ack_q;
  end

  // read mux; unmapped offsets read as zero and still ack
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i[7:4] == ul_pkg::CNT_PAGE)
      rd_mux = {8'h00, cnt_q[wb_adr_i[3:2]]};
    else
    begin
      case (wb_adr_i[7:0])
        ul_pkg::ADR_CTRL: rd_mux = {30'h0, lvl_en_q, ctrl_en_q};
        ul_pkg::ADR_IVL:  rd_mux = {20'h0_0000, ivl_q};
        ul_pkg::ADR_THR:  rd_mux = {24'h00_0000, thr_q};
        ul_pkg::ADR_STAT: rd_mux = {6'h00, wptr_q, 13'h0000,
                                    req_q, wrapped_q, active_q};
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // read data is latched as ack rises and held while ack is high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdat_q <= 32'h0000_0000;
    else if (wb_req & ~ack_q)
      rdat_q <= rd_mux;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // control registers, byte lanes honoured
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_en_q <= 1'b0;
      lvl_en_q  <= 1'b0;
      ivl_q     <= ul_pkg::IVL_RST;
      thr_q     <= ul_pkg::THR_RST;
    end
    else if (wb_wr)
    begin
      case (wb_adr_i[7:0])
        ul_pkg::ADR_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            ctrl_en_q <= wb_dat_i[ul_pkg::CTRL_EN_BIT];
            lvl_en_q  <= wb_dat_i[ul_pkg::CTRL_LVL_BIT];
          end
        end
        ul_pkg::ADR_IVL:
        begin
          if (wb_sel_i[0])
            ivl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            ivl_q[11:8] <= wb_dat_i[11:8];
        end
        ul_pkg::ADR_THR:
        begin
          if (wb_sel_i[0])
            thr_q <= wb_dat_i[7:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // any enable write is persisted so the next power-up sees it
  assign arm_set = wb_wr & wb_sel_i[0] & (wb_adr_i[7:0] == ul_pkg::ADR_CTRL);

  // one interval source feeds both logging methods
  ul_interval_timer #(
    .SEC_CYC  (SEC_CYC)
  ) u_timer (
    .clk      (clk),
    .arst_n   (arst_n),
    .run      (active_q),
    .interval (ivl_q),
    .tick     (tick)
  );

  // change detection against the last logged state
  assign chg_state = (state_i.memory != snap_q.memory)
                   | (state_i.volume_setting != snap_q.volume_setting)
                   | (state_i.battery != snap_q.battery);
  assign amb_diff = (state_i.ambient >= snap_q.ambient)
                  ? state_i.ambient - snap_q.ambient
                  : snap_q.ambient - state_i.ambient;
  assign amb_chg = lvl_en_q & (amb_diff > thr_q);

  // pending work; a new tick or enable write beats the clear of its own flag
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ent_pend_q <= 1'b0;
      cnt_pend_q <= 1'b0;
      arm_pend_q <= 1'b0;
    end
    else
    begin
      // a change seen while launching is already in that entry
      ent_pend_q <= (active_q & (tick | ((chg_state | amb_chg) & ~go_ent)))
                  | (ent_pend_q & ~go_ent);
      cnt_pend_q <= (active_q & tick) | (cnt_pend_q & ~go_cnt);
      arm_pend_q <= arm_set | (arm_pend_q & ~go_arm);
    end
  end

  // launch choice: arm word first, then entry, then counter
  assign go_arm = (st_q == ul_pkg::ST_IDLE) & arm_pend_q;
  assign go_ent = (st_q == ul_pkg::ST_IDLE) & ~arm_pend_q
                & active_q & ent_pend_q;
  assign go_cnt = (st_q == ul_pkg::ST_IDLE) & ~arm_pend_q & ~ent_pend_q
                & active_q & cnt_pend_q;

  // payload and slot of the word about to be written
  always_comb
  begin
    pay      = {1'b0, state_i};
    pay_addr = ul_pkg::ENTRY_BASE + wptr_q;
    if (go_arm)
    begin
      pay      = {23'h00_0000, ctrl_en_q};
      pay_addr = ul_pkg::ARM_ADDR;
    end
    else if (go_cnt)
    begin
      pay      = cnt_q[state_i.memory] + 24'h00_0001;
      pay_addr = ul_pkg::CNT_BASE + {8'h00, state_i.memory};
    end
  end

  ul_csum u_csum (
    .payload (pay),
    .addr    (pay_addr),
    .csum    (csum)
  );

  // writer state machine; request held until the memory acks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q  <= ul_pkg::ST_IDLE;
      req_q <= 1'b0;
      nvm_q <= '0;
    end
    else
    begin
      case (st_q)
        ul_pkg::ST_IDLE:
        begin
          if (go_arm | go_ent | go_cnt)
          begin
            req_q      <= 1'b1;
            nvm_q.addr <= pay_addr;
            nvm_q.data <= {pay, csum};
            if (go_arm)
              st_q <= ul_pkg::ST_ARM;
            else if (go_ent)
              st_q <= ul_pkg::ST_ENTRY;
            else
              st_q <= ul_pkg::ST_COUNT;
          end
        end
        ul_pkg::ST_ENTRY, ul_pkg::ST_COUNT, ul_pkg::ST_ARM:
        begin
          if (nvm_ack_i)
          begin
            req_q <= 1'b0;
            st_q  <= ul_pkg::ST_IDLE;
          end
        end
        default:
        begin
          req_q <= 1'b0;
          st_q  <= ul_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign nvm_req_o = req_q;
  assign nvm_o     = nvm_q;

  // snapshot of what the last entry recorded
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      snap_q <= '0;
    else if (go_ent)
      snap_q <= state_i;
  end

  // circular pointer; the oldest slot is reused once full
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wptr_q    <= 10'h000;
      wrapped_q <= 1'b0;
    end
    else if ((st_q == ul_pkg::ST_ENTRY) && nvm_ack_i)
    begin
      if (wptr_q == PTR_LAST)
      begin
        wptr_q    <= 10'h000;
        wrapped_q <= 1'b1;
      end
      else
        wptr_q <= wptr_q + 10'h001;
    end
  end

  // shadow usage counters; they restart from zero each power-up
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_mem_q <= 2'h0;
    else if (go_cnt)
      cnt_mem_q <= state_i.memory;
  end

  for (genvar g = 0; g < ul_pkg::MEM_STATES; g++)
  begin : g_cnt
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        cnt_q[g] <= '0;
      else if (go_cnt && (state_i.memory == 2'(g)))
        cnt_q[g] <= cnt_q[g] + 24'h00_0001;
    end
  end

  a_idle_when_off: assert property (
    !active_q && nvm_req_o |-> nvm_o.addr == ul_pkg::ARM_ADDR)
    else $error("log write while logging is off");
  a_ptr_wrap: assert property (
    st_q == ul_pkg::ST_ENTRY && nvm_ack_i && wptr_q == PTR_LAST
    |=> wptr_q == 10'h000 && wrapped_q)
    else $error("entry pointer failed to wrap");
  a_ptr_step: assert property (
    st_q == ul_pkg::ST_ENTRY && nvm_ack_i && wptr_q != PTR_LAST
    |=> wptr_q == $past(wptr_q) + 10'h001)
    else $error("entry pointer step wrong");
  a_csum_word: assert property (nvm_req_o |-> nvm_o.data[7:0] ==
    ~(nvm_o.data[31:24] + nvm_o.data[23:16] + nvm_o.data[15:8]
      + nvm_o.addr[7:0] + {6'h00, nvm_o.addr[9:8]}))
    else $error("stored word checksum mismatch");
  a_req_hold: assert property (nvm_req_o && !nvm_ack_i
    |=> nvm_req_o && $stable(nvm_o))
    else $error("log write dropped before ack");
  a_tick_both: assert property (tick && active_q && st_q == ul_pkg::ST_IDLE
    && !arm_pend_q ##1 st_q == ul_pkg::ST_IDLE
    |-> ##[1:40] st_q == ul_pkg::ST_COUNT)
    else $error("interval did not reach usage counter");
  a_cnt_incr: assert property (go_cnt
    |=> cnt_q[cnt_mem_q] == $past(cnt_q[state_i.memory]) + 24'h00_0001)
    else $error("usage counter not incremented");
  a_change_entry: assert property (active_q && chg_state && !go_ent
    |=> ent_pend_q)
    else $error("state change not queued");
  a_level_gate: assert property (!lvl_en_q |-> !amb_chg)
    else $error("ambient logging while disabled");
  a_entry_fields: assert property (go_ent
    |=> nvm_o.data[30:8] == $past(state_i))
    else $error("entry fields not as sampled");
  a_wb_ack: assert property (wb_req && !ack_q |=> ack_q)
    else $error("bus ack late");
endmodule // ul_logger

// *** rtl/ul_pkg.sv ***
// shared constants and carrier types for the usage logger
package ul_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ONE_SEC_NS    = 1_000_000_000;
  localparam int unsigned SEC_CYC       = ONE_SEC_NS / CLK_PERIOD_NS;
  // programmable sampling interval, in seconds
  localparam int unsigned IVL_W         = 12;
  localparam int unsigned IVL_MIN_S     = 4;
  localparam int unsigned IVL_MAX_MIN   = 60;
  localparam int unsigned IVL_MAX_S     = IVL_MAX_MIN * 60;
  // log layout in non-volatile memory, word addressed
  localparam int unsigned ENTRIES       = 750;
  localparam int unsigned MEM_STATES    = 4;
  localparam int unsigned NVM_AW        = 10;
  localparam logic [9:0]  ENTRY_BASE    = 10'h000;
  localparam logic [9:0]  CNT_BASE      = 10'h2EE;
  localparam logic [9:0]  ARM_ADDR      = 10'h2F2;
  localparam int unsigned PAY_W         = 24;
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned CSUM_W        = 8;
  // register offsets on the bus
  localparam logic [7:0]  ADR_CTRL      = 8'h00;
  localparam logic [7:0]  ADR_IVL       = 8'h04;
  localparam logic [7:0]  ADR_THR       = 8'h08;
  localparam logic [7:0]  ADR_STAT      = 8'h0C;
  localparam logic [3:0]  CNT_PAGE      = 4'h1;
  // control fields and reset values
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_LVL_BIT  = 1;
  localparam logic [11:0] IVL_RST       = 12'h03C;
  localparam logic [7:0]  THR_RST       = 8'h10;
  // power-up capture of the arm flag
  localparam logic [1:0]  CAP_LAST      = 2'h2;
  localparam logic [1:0]  CAP_DONE      = 2'h3;

  // one short-term sample of the device state
  typedef struct packed {
    logic [3:0] battery;
    logic [5:0] volume_setting;
    logic [1:0] memory;
    logic [2:0] env;
    logic [7:0] ambient;
  } ul_entry_t;

  // one word write toward the log memory
  typedef struct packed {
    logic [9:0]  addr;
    logic [31:0] data;
  } ul_nvm_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_COUNT, ST_ARM} ul_state_t;
endpackage

// *** test/ul_logger_tb.sv ***
// self-checking bench for the usage logger
`timescale 1ns/1ps
`define UL_CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module ul_logger_tb;
  localparam int unsigned SC = 8;  // shortened second, in cycles
  localparam int unsigned NE = 4;  // short ring so the wrap comes soon

  logic              clk;
  logic              arst_n;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [31:0]       wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  ul_pkg::ul_entry_t st;         // sampled device state
  logic              nvm_arm;
  logic              nvm_req;
  ul_pkg::ul_nvm_t   nvm_w;
  logic              nvm_ack;
  logic [3:0]        ack_wait;   // memory answer delay
  logic              got;
  ul_pkg::ul_nvm_t   word;
  ul_pkg::ul_nvm_t   wq[$];      // words the memory took, oldest first
  int                tq[$];      // cycle at which each word was taken
  int                cyc_n = 0;
  int                t_last = 0;
  int                bad_count = 0;
  int                n_checks = 0;
  logic [31:0]       rd;         // last read data

  ul_logger #(.SEC_CYC(SC), .ENTRIES(NE)) dut_u (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .state_i(st), .nvm_arm_i(nvm_arm), .nvm_req_o(nvm_req),
    .nvm_o(nvm_w), .nvm_ack_i(nvm_ack)
  );

  ul_nvm_model nvm_u (
    .clk(clk), .nvm_req_o(nvm_req), .nvm_o(nvm_w), .ack_wait(ack_wait),
    .nvm_ack_i(nvm_ack), .nvm_arm_i(nvm_arm), .got_o(got), .word_o(word)
  );

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // collect memory writes and cut a hung run short
  always @(posedge clk)
  begin
    cyc_n++;
    if (got)
    begin
      wq.push_back(word);
      tq.push_back(cyc_n);
    end
    if (cyc_n == 20000)
    begin
      bad_count++;
      $display("[FAIL] run cycles expected below 20000 seen 20000");
      results();
    end
  end

  // expected checksum, worked out independently of the design
  function automatic logic [7:0] csum(logic [9:0] a, logic [23:0] p);
    return ~(p[23:16] + p[15:8] + p[7:0] + a[7:0] + {6'h0, a[9:8]});
  endfunction

  // one classic single Wishbone access; waits for ack, bounded
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= wd;
    wb_sel_i <= 4'h3;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    `UL_CHK("wb ack", 1'b1, wb_ack_o);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  // next word taken by the memory, with a bounded wait
  task automatic pop(output ul_pkg::ul_nvm_t w);
    int n;
    n = 0;
    w = '0;
    while (wq.size() == 0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    `UL_CHK("nvm write", 1'b1, wq.size() > 0);
    if (wq.size() > 0)
    begin
      w = wq.pop_front();
      t_last = tq.pop_front();
    end
  endtask

  task automatic ex_word(input logic [9:0] a, input logic [23:0] p);
    ul_pkg::ul_nvm_t w;
    pop(w);
    `UL_CHK("nvm addr", a, w.addr);
    `UL_CHK("nvm payload", p, w.data[31:8]);
    `UL_CHK("nvm csum", csum(a, p), w.data[7:0]);
  endtask

  task automatic ex_ent(input logic [9:0] a, input ul_pkg::ul_entry_t v);
    ex_word(a, {1'b0, v});
  endtask

  task automatic ex_arm(input logic b);
    ul_pkg::ul_nvm_t w;
    pop(w);
    `UL_CHK("arm addr", ul_pkg::ARM_ADDR, w.addr);
    `UL_CHK("arm bit", b, w.data[8]);
    `UL_CHK("arm csum", csum(w.addr, w.data[31:8]), w.data[7:0]);
  endtask

  // state change lands one edge later
  task automatic set_st(input ul_pkg::ul_entry_t v);
    st <= v;
    @(posedge clk);
  endtask

  // no memory write may appear within n cycles
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    `UL_CHK("idle writes", 0, wq.size());
  endtask

  // register defaults, and nothing logged before the arming power-up
  task automatic t_unarmed;
    ul_pkg::ul_entry_t v;
    v = '0;
    wb(1'b0, ul_pkg::ADR_IVL, 32'h0);
    `UL_CHK("ivl reset", {20'h0, ul_pkg::IVL_RST}, rd);
    wb(1'b0, ul_pkg::ADR_THR, 32'h0);
    `UL_CHK("thr reset", {24'h0, ul_pkg::THR_RST}, rd);
    wb(1'b0, 8'h40, 32'h0);
    `UL_CHK("unmapped read", 32'h0, rd);
    wb(1'b1, ul_pkg::ADR_IVL, 32'h4);
    wb(1'b0, ul_pkg::ADR_IVL, 32'h0);
    `UL_CHK("ivl minimum", 32'h4, rd);
    v.volume_setting = 6'h09;
    set_st(v);
    repeat (100) @(posedge clk);
    `UL_CHK("unarmed writes", 0, wq.size());
    set_st('0);
    wb(1'b1, ul_pkg::ADR_CTRL, 32'h1);
    ex_arm(1'b1);
    wb(1'b0, ul_pkg::ADR_STAT, 32'h0);
    `UL_CHK("active early", 1'b0, rd[0]);
    $display("test unarmed done");
  endtask

  // second power-up picks up the stored arm word
  task automatic powerup;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    wb(1'b0, ul_pkg::ADR_STAT, 32'h0);
    `UL_CHK("active", 1'b1, rd[0]);
    `UL_CHK("ring ptr", 10'h0, rd[25:16]);
    $display("test powerup done");
  endtask

  // change-driven entries, ambient threshold edge and disable
  task automatic t_change;
    ul_pkg::ul_entry_t v;
    v = '0;
    wb(1'b1, ul_pkg::ADR_CTRL, 32'h3);
    ex_arm(1'b1);
    v.volume_setting = 6'h05;
    v.memory = 2'h2;
    set_st(v);
    ex_ent(10'h000, v);
    v.ambient = 8'h11;
    set_st(v);
    ex_ent(10'h001, v);
    v.ambient = 8'h21;
    set_st(v);
    quiet(40);
    wb(1'b1, ul_pkg::ADR_CTRL, 32'h1);
    ex_arm(1'b1);
    v.ambient = 8'h90;
    set_st(v);
    quiet(40);
    v.battery = 4'h3;
    set_st(v);
    ex_ent(10'h002, v);
    $display("test change done");
  endtask

  // interval ticks with a slow memory: entry, counter, ring wrap
  task automatic t_ticks;
    int t0;
    ack_wait <= 4'h5;
    wb(1'b1, ul_pkg::ADR_IVL, 32'h4);
    ex_ent(10'h003, st);
    t0 = t_last;
    ex_word(ul_pkg::CNT_BASE + 10'h2, 24'h1);
    ex_ent(10'h000, st);
    `UL_CHK("tick gap", 4 * SC, t_last - t0);
    ex_word(ul_pkg::CNT_BASE + 10'h2, 24'h2);
    wb(1'b0, ul_pkg::ADR_STAT, 32'h0);
    `UL_CHK("wrapped", 1'b1, rd[1]);
    `UL_CHK("ring ptr", 10'h1, rd[25:16]);
    wb(1'b0, 8'h18, 32'h0);
    `UL_CHK("usage count", 24'h2, rd[23:0]);
    $display("test ticks done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial
  begin
    arst_n   = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    st       = '0;
    ack_wait = 4'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_unarmed();
    powerup();
    t_change();
    t_ticks();
    results();
  end
endmodule // ul_logger_tb

// *** test/ul_nvm_model.sv ***
// log memory model that accepts the logger's word writes
`timescale 1ns/1ps
module ul_nvm_model (
  input  wire logic            clk,
  input  wire logic            nvm_req_o,
  input  wire ul_pkg::ul_nvm_t nvm_o,
  input  wire logic [3:0]      ack_wait,
  output logic                 nvm_ack_i,
  output logic                 nvm_arm_i,
  output logic                 got_o,
  output ul_pkg::ul_nvm_t      word_o
);
  logic [3:0] wait_q;  // cycles the current request has been held

  // power-on contents: never armed, no write in flight
  initial
  begin
    nvm_ack_i = 1'b0;
    nvm_arm_i = 1'b0;
    got_o     = 1'b0;
    word_o    = '0;
    wait_q    = 4'h0;
  end

  // take a word after ack_wait cycles; ack is a single-cycle pulse
  always @(posedge clk)
  begin
    got_o <= 1'b0;
    if (nvm_ack_i)
      nvm_ack_i <= 1'b0;
    else if (nvm_req_o)
    begin
      // a slow memory keeps the logger busy, so events must queue
      if (wait_q < ack_wait)
        wait_q <= wait_q + 4'h1;
      else
      begin
        nvm_ack_i <= 1'b1;
        wait_q    <= 4'h0;
        got_o     <= 1'b1;
        word_o    <= nvm_o;
        // arm word survives power cycles, unlike the logger itself
        if (nvm_o.addr == ul_pkg::ARM_ADDR)
          nvm_arm_i <= nvm_o.data[8];
      end
    end
  end
endmodule // ul_nvm_model
